// >>> hw/spm_div.sv
// enable divider producing one tick per DIV input enables
`timescale 1ns/1ns
module spm_div #(
   parameter int DIV = 4
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // control
   input wire logic i_en,
   input wire logic i_clr,
   // tick
   output logic o_tick
);
   localparam int CW = (DIV < 2) ? 1 : $clog2(DIV);

   generate
      if (DIV < 2) begin : g_bad_div
         $error("spm_div needs DIV of at least 2");
      end
   endgenerate

   logic [CW-1:0] cnt_q;

   assign o_tick = i_en && !i_clr && (cnt_q == CW'(DIV - 1));

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= '0;
      end else if (i_clr) begin
         cnt_q <= '0;
      end else if (i_en) begin
         cnt_q <= o_tick ? '0 : cnt_q + 1'b1;
      end
   end
endmodule : spm_div

// >>> hw/spm_pkg.sv
// shared constants, register map and decoders for the protection monitors
package spm_pkg;
   localparam int DW = 16;
   localparam int AW = 8;

   // register byte offsets
   localparam logic [7:0] OFS_MCR = 8'h00;
   localparam logic [7:0] OFS_PCR = 8'h04;
   localparam logic [7:0] OFS_SVC = 8'h08;
   localparam logic [7:0] OFS_PTR = 8'h0c;
   localparam logic [7:0] OFS_PERIODIC_CONTROL_REG = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;

   // module_config_reg fields
   localparam int MCR_SHOW_LO = 0;
   localparam int MCR_SLV = 2;
   localparam int MCR_PRIV = 3;
   localparam logic [1:0] MCR_SHOW_RST = 2'h0;
   localparam logic MCR_PRIV_RST = 1'h1;

   // protection_control_reg fields
   localparam int PCR_BMT_LO = 0;
   localparam int PCR_BME = 2;
   localparam int PCR_HME = 3;
   localparam int PCR_SWT_LO = 4;
   localparam int PCR_SWP = 6;
   localparam int PCR_SWE = 7;
   localparam logic [1:0] PCR_BMT_RST = 2'h0;
   localparam logic PCR_BME_RST = 1'h0;
   localparam logic PCR_HME_RST = 1'h0;
   localparam logic [1:0] PCR_SWT_RST = 2'h0;
   localparam logic PCR_SWP_RST = 1'h1;
   localparam logic PCR_SWE_RST = 1'h0;

   // periodic_timing_reg and periodic_control_reg fields
   localparam int PTR_MOD_LO = 0;
   localparam int PTR_PTP = 8;
   localparam logic [7:0] PTR_MOD_RST = 8'h00;
   localparam logic PTR_PTP_RST = 1'h1;
   localparam int PERIODIC_CONTROL_REG_VEC_LO = 0;
   localparam int PERIODIC_CONTROL_REG_LVL_LO = 8;
   localparam logic [7:0] PERIODIC_CONTROL_REG_VEC_RST = 8'h0f;
   localparam logic [2:0] PERIODIC_CONTROL_REG_LVL_RST = 3'h0;

   // status register fields
   localparam int STAT_PEND = 0;
   localparam int STAT_ARMED = 1;

   // service keys and timing
   localparam logic [7:0] SVC_ARM = 8'h55;
   localparam logic [7:0] SVC_FIRE = 8'haa;
   localparam int PRESCALE_DIV = 512;
   localparam int PIT_DIV = 4;
   localparam logic [15:0] WD_BASE = 16'h0200;
   localparam logic [1:0] STRAP_DONE = 2'h2;

   typedef enum logic [1:0] {
      BM_IDLE = 2'h0,
      BM_FIRST = 2'h1,
      BM_WAIT = 2'h3
   } spm_bm_e;

   function automatic logic [6:0] bm_limit(input logic [1:0] sel);
      unique case (sel)
         2'h0: bm_limit = 7'h40;
         2'h1: bm_limit = 7'h20;
         2'h2: bm_limit = 7'h10;
         2'h3: bm_limit = 7'h08;
      endcase
   endfunction : bm_limit

   // ticks of the (optionally prescaled) clock before expiry: 2^9 .. 2^15
   function automatic logic [15:0] wd_limit(input logic [1:0] watchdog_timing_field);
      wd_limit = WD_BASE << {watchdog_timing_field, 1'b0};
   endfunction : wd_limit
endpackage : spm_pkg

// >>> hw/spm_top.sv
// system protection monitors: config, bus/halt/spurious monitors, watchdog, periodic timer
//
// Contract
// - show select 00 arbitration only, 01 show only, else both
// - read-only slave flag captures strap, low enables
// - privilege bit set blocks user register access
// - bus monitor counts, faults on missing acknowledge
// - timeout select gives 64, 32, 16, 8 clocks
// - monitor core cycles; enable gates external ones
// - word to byte port counts both accesses
// - halt request resets only when enabled
// - unarbitrated interrupt acknowledge faults, always on
// - enabled watchdog resets unless serviced in time
// - service is 55 then AA, gaps allowed
// - watchdog prescale loads from clock mode strap
// - watchdog ratio 2^9..2^15, prescaled 2^18..2^24
// - new watchdog timing waits for a service
// - periodic clock is reference, prescaled, divided four
// - periodic prescale loads from strap, stays writable
// - zero modulus stops, nonzero starts the counter
// - at zero, interrupt, reload, keep counting
// - new modulus loads when current count completes
// - level 0 disables, 1..6 compared with mask, 7 taken at any mask
// - periodic wins ties; counter runs while disabled
// - acknowledge drives vector; vector resets to 0f
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module spm_top #(
   parameter int PRE_DIV = spm_pkg::PRESCALE_DIV,
   parameter int PIT_DIV = spm_pkg::PIT_DIV
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // register port
   input wire logic [spm_pkg::AW-1:0] i_addr,
   input wire logic [spm_pkg::DW-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_super,
   output logic [spm_pkg::DW-1:0] o_rdata,
   // reset straps (pins)
   input wire logic i_clock_mode_strap,
   input wire logic i_test_strap_line,
   // bus cycle watch
   input wire logic i_cyc_start,
   input wire logic i_cyc_core,
   input wire logic i_cyc_ext,
   input wire logic i_cyc_word8,
   input wire logic i_transfer_size_ack,
   input wire logic i_autovector_request,
   input wire logic i_halt_req,
   // interrupts
   input wire logic i_reference_clock_input,
   input wire logic [2:0] i_cpu_mask,
   input wire logic [2:0] i_ext_irq_level,
   input wire logic i_iack,
   input wire logic [2:0] i_iack_level,
   input wire logic i_iack_arb,
   // outputs
   output logic o_show_cycles_en,
   output logic o_ext_arb_en,
   output logic o_bus_fault_signal,
   output logic o_sys_reset,
   output logic [2:0] o_irq_level,
   output logic o_irq_from_pit,
   output logic o_vec_valid,
   output logic [7:0] o_vec_data
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_nrst);

   // pin synchronisers: stage one feeds stage two only
   localparam int NS = 8;
   logic [NS-1:0] pin_s1_q;
   logic [NS-1:0] pin_s2_q;
   logic ref_s3_q;
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         ref_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= {i_ext_irq_level, i_test_strap_line, i_clock_mode_strap,
                      i_reference_clock_input, i_autovector_request, i_transfer_size_ack};
         pin_s2_q <= pin_s1_q;
         ref_s3_q <= pin_s2_q[2];
      end
   end
   wire logic ack = pin_s2_q[0] || pin_s2_q[1];
   wire logic ref_rise = pin_s2_q[2] && !ref_s3_q;
   wire logic mode_s = pin_s2_q[3];
   wire logic test_s = pin_s2_q[4];
   wire logic [2:0] ext_lvl = pin_s2_q[7:5];

   // register state
   logic [1:0] show_q;
   logic slv_q;
   logic priv_q;
   logic [1:0] bmt_q;
   logic bme_q;
   logic hme_q;
   logic [1:0] swt_q;
   logic swp_q;
   logic swe_q;
   logic [7:0] periodic_modulus_field_q;
   logic ptp_q;
   logic [7:0] vec_q;
   logic [2:0] lvl_q;
   logic [1:0] strap_cnt_q;
   logic pend_q;
   logic armed_q;

   wire logic acc_ok = i_super || !priv_q;
   wire logic wr_ok = i_wr && acc_ok;
   wire logic mcr_wr = wr_ok && (i_addr == spm_pkg::OFS_MCR);
   wire logic pcr_wr = wr_ok && (i_addr == spm_pkg::OFS_PCR);
   wire logic svc_wr = wr_ok && (i_addr == spm_pkg::OFS_SVC);
   wire logic ptr_wr = wr_ok && (i_addr == spm_pkg::OFS_PTR);
   wire logic periodic_control_reg_wr = wr_ok && (i_addr == spm_pkg::OFS_PERIODIC_CONTROL_REG);
   wire logic strap_take = (strap_cnt_q == spm_pkg::STRAP_DONE);
   wire logic [7:0] wr_mod = i_wdata[spm_pkg::PTR_MOD_LO +: 8];

   // straps settle through the synchroniser, then are caught once
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         strap_cnt_q <= 2'h0;
      end else if (strap_cnt_q != 2'h3) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         show_q <= spm_pkg::MCR_SHOW_RST;
         priv_q <= spm_pkg::MCR_PRIV_RST;
         slv_q <= 1'b0;
      end else begin
         if (mcr_wr) begin
            show_q <= i_wdata[spm_pkg::MCR_SHOW_LO +: 2];
            priv_q <= i_wdata[spm_pkg::MCR_PRIV];
         end
         if (strap_take) begin
            slv_q <= !test_s;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         bmt_q <= spm_pkg::PCR_BMT_RST;
         bme_q <= spm_pkg::PCR_BME_RST;
         hme_q <= spm_pkg::PCR_HME_RST;
         swt_q <= spm_pkg::PCR_SWT_RST;
         swp_q <= spm_pkg::PCR_SWP_RST;
         swe_q <= spm_pkg::PCR_SWE_RST;
      end else begin
         if (pcr_wr) begin
            bmt_q <= i_wdata[spm_pkg::PCR_BMT_LO +: 2];
            bme_q <= i_wdata[spm_pkg::PCR_BME];
            hme_q <= i_wdata[spm_pkg::PCR_HME];
            swt_q <= i_wdata[spm_pkg::PCR_SWT_LO +: 2];
            swp_q <= i_wdata[spm_pkg::PCR_SWP];
            swe_q <= i_wdata[spm_pkg::PCR_SWE];
         end
         if (strap_take) begin
            swp_q <= !mode_s;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         periodic_modulus_field_q <= spm_pkg::PTR_MOD_RST;
         ptp_q <= spm_pkg::PTR_PTP_RST;
         vec_q <= spm_pkg::PERIODIC_CONTROL_REG_VEC_RST;
         lvl_q <= spm_pkg::PERIODIC_CONTROL_REG_LVL_RST;
      end else begin
         if (ptr_wr) begin
            periodic_modulus_field_q <= wr_mod;
            ptp_q <= i_wdata[spm_pkg::PTR_PTP];
         end
         if (strap_take) begin
            ptp_q <= !mode_s;
         end
         if (periodic_control_reg_wr) begin
            vec_q <= i_wdata[spm_pkg::PERIODIC_CONTROL_REG_VEC_LO +: 8];
            lvl_q <= i_wdata[spm_pkg::PERIODIC_CONTROL_REG_LVL_LO +: 3];
         end
      end
   end

   // read port: data only in the cycle after the strobe
   logic [spm_pkg::DW-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      unique case (i_addr)
         spm_pkg::OFS_MCR: begin
            rd_mux[spm_pkg::MCR_SHOW_LO +: 2] = show_q;
            rd_mux[spm_pkg::MCR_SLV] = slv_q;
            rd_mux[spm_pkg::MCR_PRIV] = priv_q;
         end
         spm_pkg::OFS_PCR: begin
            rd_mux[spm_pkg::PCR_BMT_LO +: 2] = bmt_q;
            rd_mux[spm_pkg::PCR_BME] = bme_q;
            rd_mux[spm_pkg::PCR_HME] = hme_q;
            rd_mux[spm_pkg::PCR_SWT_LO +: 2] = swt_q;
            rd_mux[spm_pkg::PCR_SWP] = swp_q;
            rd_mux[spm_pkg::PCR_SWE] = swe_q;
         end
         spm_pkg::OFS_PTR: begin
            rd_mux[spm_pkg::PTR_MOD_LO +: 8] = periodic_modulus_field_q;
            rd_mux[spm_pkg::PTR_PTP] = ptp_q;
         end
         spm_pkg::OFS_PERIODIC_CONTROL_REG: begin
            rd_mux[spm_pkg::PERIODIC_CONTROL_REG_VEC_LO +: 8] = vec_q;
            rd_mux[spm_pkg::PERIODIC_CONTROL_REG_LVL_LO +: 3] = lvl_q;
         end
         spm_pkg::OFS_STAT: begin
            rd_mux[spm_pkg::STAT_PEND] = pend_q;
            rd_mux[spm_pkg::STAT_ARMED] = armed_q;
         end
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= (i_rd && acc_ok) ? rd_mux : '0;
      end
   end

   priv_block_a: assert property (i_wr && !i_super && priv_q && i_addr == spm_pkg::OFS_PERIODIC_CONTROL_REG
      |=> $stable({vec_q, lvl_q}))
      else $error("user write changed a protected register");

   // show cycle decode
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_show_cycles_en <= 1'b0;
         o_ext_arb_en <= 1'b1;
      end else begin
         o_show_cycles_en <= (show_q != 2'h0);
         o_ext_arb_en <= (show_q != 2'h1);
      end
   end

   show_map_a: assert property (show_q == 2'h1 |=> o_show_cycles_en && !o_ext_arb_en)
      else $error("show select 01 decoded wrongly");

   // bus monitor
   spm_pkg::spm_bm_e bm_st_q;
   logic [6:0] bm_cnt_q;
   wire logic [6:0] bm_lim = spm_pkg::bm_limit(bmt_q);
   wire logic bm_start = i_cyc_start && i_cyc_core && (!i_cyc_ext || bme_q);
   wire logic bm_to = (bm_st_q != spm_pkg::BM_IDLE) && !ack && (bm_cnt_q == bm_lim - 7'h1);

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         bm_st_q <= spm_pkg::BM_IDLE;
         bm_cnt_q <= 7'h0;
      end else begin
         bm_cnt_q <= bm_cnt_q + 7'h1;
         unique case (bm_st_q)
            spm_pkg::BM_IDLE: begin
               bm_cnt_q <= 7'h0;
               if (bm_start) begin
                  bm_st_q <= i_cyc_word8 ? spm_pkg::BM_FIRST : spm_pkg::BM_WAIT;
               end
            end
            spm_pkg::BM_FIRST: begin
               // first byte acknowledged: the count keeps running
               if (bm_to) begin
                  bm_st_q <= spm_pkg::BM_IDLE;
               end else if (ack) begin
                  bm_st_q <= spm_pkg::BM_WAIT;
               end
            end
            spm_pkg::BM_WAIT: begin
               if (bm_to || ack) begin
                  bm_st_q <= spm_pkg::BM_IDLE;
               end
            end
            default: bm_st_q <= spm_pkg::BM_IDLE;
         endcase
      end
   end

   bus_timeout_a: assert property (bm_st_q == spm_pkg::BM_IDLE && bm_start && bmt_q == 2'h3
      ##1 (!ack && bmt_q == 2'h3) [*8] |=> o_bus_fault_signal)
      else $error("bus monitor missed the 8 clock timeout");

   byte_pair_a: assert property (bm_st_q == spm_pkg::BM_FIRST && ack && !bm_to
      |=> bm_st_q == spm_pkg::BM_WAIT && bm_cnt_q == $past(bm_cnt_q) + 7'h1)
      else $error("bus monitor restarted between byte accesses");

   // periodic timer clock chain
   logic pre512_tick;
   logic pit_tick;
   wire logic pre_tick = ptp_q ? pre512_tick : ref_rise;

   spm_div #(.DIV(PRE_DIV)) u_pit_pre (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_en(ref_rise),
      .i_clr(1'b0),
      .o_tick(pre512_tick)
   );

   spm_div #(.DIV(PIT_DIV)) u_pit_div4 (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_en(pre_tick),
      .i_clr(1'b0),
      .o_tick(pit_tick)
   );

   // modulus counter; zero means stopped
   logic [7:0] pit_cnt_q;
   wire logic pit_done = pit_tick && (pit_cnt_q == 8'h1) && !(ptr_wr && wr_mod == 8'h0);
   wire logic [7:0] reload = ptr_wr ? wr_mod : periodic_modulus_field_q;

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         pit_cnt_q <= 8'h0;
      end else if (ptr_wr && wr_mod == 8'h0) begin
         pit_cnt_q <= 8'h0;
      end else if (ptr_wr && pit_cnt_q == 8'h0) begin
         pit_cnt_q <= wr_mod;
      end else if (pit_done) begin
         pit_cnt_q <= reload;
      end else if (pit_tick && pit_cnt_q != 8'h0) begin
         pit_cnt_q <= pit_cnt_q - 8'h1;
      end
   end

   pit_stop_a: assert property (ptr_wr && wr_mod == 8'h0 |=> pit_cnt_q == 8'h0)
      else $error("zero modulus did not stop the timer");

   pit_reload_a: assert property (pit_done && !ptr_wr |=> pit_cnt_q == $past(periodic_modulus_field_q))
      else $error("modulus counter not reloaded at zero");

   pit_keep_a: assert property (ptr_wr && pit_cnt_q > 8'h1 && !pit_tick && wr_mod != 8'h0
      |=> pit_cnt_q == $past(pit_cnt_q))
      else $error("modulus write disturbed the running count");

   // periodic request, priority and vector
   wire logic pit_req = pend_q && (lvl_q != 3'h0);
   wire logic pit_rec = pit_req && (lvl_q > i_cpu_mask || lvl_q == 3'h7);
   wire logic pit_hit = i_iack && pit_req && (i_iack_level == lvl_q);

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         pend_q <= 1'b0;
      end else if (pit_done && lvl_q != 3'h0) begin
         pend_q <= 1'b1;
      end else if (pit_hit) begin
         pend_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_irq_level <= 3'h0;
         o_irq_from_pit <= 1'b0;
         o_vec_valid <= 1'b0;
         o_vec_data <= 8'h0;
      end else begin
         o_irq_level <= (pit_rec && lvl_q >= ext_lvl) ? lvl_q : ext_lvl;
         o_irq_from_pit <= pit_rec && (lvl_q >= ext_lvl);
         o_vec_valid <= pit_hit;
         o_vec_data <= pit_hit ? vec_q : 8'h0;
      end
   end

   vec_drive_a: assert property (pit_hit |=> o_vec_valid && o_vec_data == $past(vec_q))
      else $error("periodic vector not driven on acknowledge");

   pit_tie_a: assert property (pit_rec && lvl_q == ext_lvl |=> o_irq_from_pit)
      else $error("periodic request lost a tie");

   // watchdog
   logic wd_pre_tick;
   logic [1:0] swt_act_q;
   logic [15:0] wd_cnt_q;
   wire logic svc_fire = svc_wr && (i_wdata[7:0] == spm_pkg::SVC_FIRE) && armed_q;
   wire logic wd_tick = swe_q && (swp_q ? wd_pre_tick : 1'b1);
   wire logic [15:0] wd_lim = spm_pkg::wd_limit(swt_act_q);
   wire logic wd_to = wd_tick && !svc_fire && (wd_cnt_q == wd_lim - 16'h1);

   spm_div #(.DIV(PRE_DIV)) u_wd_pre (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_en(swe_q),
      .i_clr(svc_fire),
      .o_tick(wd_pre_tick)
   );

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         armed_q <= 1'b0;
      end else if (svc_wr) begin
         armed_q <= (i_wdata[7:0] == spm_pkg::SVC_ARM);
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         swt_act_q <= spm_pkg::PCR_SWT_RST;
      end else if (svc_fire) begin
         swt_act_q <= swt_q;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         wd_cnt_q <= 16'h0;
      end else if (!swe_q || svc_fire || wd_to) begin
         wd_cnt_q <= 16'h0;
      end else if (wd_tick) begin
         wd_cnt_q <= wd_cnt_q + 16'h1;
      end
   end

   svc_restart_a: assert property (svc_fire |=> wd_cnt_q == 16'h0 && !armed_q)
      else $error("service did not restart the watchdog");

   swt_hold_a: assert property (!svc_fire |=> $stable(swt_act_q))
      else $error("watchdog period changed without service");

   wd_expire_a: assert property (swe_q && !swp_q && swt_act_q == 2'h0 && wd_cnt_q == 16'h01ff
      && !svc_fire |=> o_sys_reset)
      else $error("watchdog did not expire at 512 clocks");

   // halt, spurious and reset outputs
   logic halt_q;
   wire logic halt_rise = i_halt_req && !halt_q;
   wire logic spur = i_iack && !i_iack_arb && !pit_hit;

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         halt_q <= 1'b0;
         o_bus_fault_signal <= 1'b0;
         o_sys_reset <= 1'b0;
      end else begin
         halt_q <= i_halt_req;
         o_bus_fault_signal <= bm_to || spur;
         o_sys_reset <= wd_to || (halt_rise && hme_q);
      end
   end

   spur_fault_a: assert property (i_iack && !i_iack_arb && !pit_hit |=> o_bus_fault_signal)
      else $error("spurious acknowledge gave no bus fault");

   halt_inhibit_a: assert property (halt_rise && !hme_q && !wd_to |=> !o_sys_reset)
      else $error("halt reset not inhibited");
endmodule : spm_top

// >>> test/spm_far.sv
// far-side model: bus cycle acknowledger and free-running reference clock
`timescale 1ns/1ns
module spm_far (
   // clock
   input wire logic i_clk_sys,
   // bench control
   input wire logic i_cyc_start,
   input wire logic [1:0] i_n_ack,
   input wire logic [7:0] i_dly,
   // pins
   output logic o_ack,
   output logic o_ref
);
   int cnt = 0;
   int left = 0;
   initial o_ack = 1'b0;
   initial o_ref = 1'b0;
   // reference runs free at ten system clocks a period
   always #20 o_ref = ~o_ref;
   // zero acks models a dead slave, two models a byte-wide port
   always @(posedge i_clk_sys) begin
      o_ack <= 1'b0;
      if (i_cyc_start) begin
         left <= i_n_ack;
         cnt <= 0;
      end else if (left != 0) begin
         cnt <= cnt + 1;
         if (cnt + 1 == i_dly) begin
            o_ack <= 1'b1;
            left <= left - 1;
            cnt <= 0;
         end
      end
   end
endmodule : spm_far

// >>> test/spm_top_tb.sv
// self-checking bench for the protection monitors
`timescale 1ns/1ns
module spm_top_tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic sup = 1'b1;
   logic start = 1'b0;
   logic core = 1'b0;
   logic ext = 1'b0;
   logic w8 = 1'b0;
   logic halt = 1'b0;
   logic [2:0] ext_lvl = 3'h0;
   logic [2:0] mask = 3'h0;
   logic autovector_request = 1'b0;
   logic iack = 1'b0;
   logic [2:0] iack_lvl = 3'h0;
   logic arb = 1'b0;
   logic [1:0] n_ack = 2'h0;
   logic [7:0] dly = 8'h02;
   logic ack, ref_clk, show, arben, fault, sreset, from_pit, vv;
   logic [15:0] rdata;
   logic [2:0] lvl;
   logic [7:0] vec;
   int n_fail = 0;
   int checked = 0;
   int n, n0;
   always #2 clk = ~clk;

   // small dividers keep the periodic timer runs short
   spm_top #(.PRE_DIV(4), .PIT_DIV(2)) u_dut (
      .i_clk_sys(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .i_super(sup), .o_rdata(rdata), .i_clock_mode_strap(1'b0), .i_test_strap_line(1'b0),
      .i_cyc_start(start), .i_cyc_core(core), .i_cyc_ext(ext), .i_cyc_word8(w8),
      .i_transfer_size_ack(ack), .i_autovector_request(autovector_request), .i_halt_req(halt),
      .i_reference_clock_input(ref_clk), .i_cpu_mask(mask), .i_ext_irq_level(ext_lvl),
      .i_iack(iack), .i_iack_level(iack_lvl), .i_iack_arb(arb), .o_show_cycles_en(show),
      .o_ext_arb_en(arben), .o_bus_fault_signal(fault), .o_sys_reset(sreset), .o_irq_level(lvl),
      .o_irq_from_pit(from_pit), .o_vec_valid(vv), .o_vec_data(vec));
   spm_far u_far (.i_clk_sys(clk), .i_cyc_start(start), .i_n_ack(n_ack), .i_dly(dly),
      .o_ack(ack), .o_ref(ref_clk));

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // a gap cycle after each strobe so no signal is assigned twice in one step
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      chk(rdata, e);
   endtask : rd_chk

   // outputs are read at the edge, before that edge's updates land
   task automatic wt(input int s, input int lim, output int c);
      logic hit;
      c = 0;
      hit = 1'b0;
      while (!hit && c < lim) begin
         @(posedge clk);
         c++;
         hit = (s == 0) ? fault === 1'b1 : (s == 1) ? sreset === 1'b1 : from_pit === 1'b1;
      end
   endtask : wt

   task automatic bus_cyc(input logic c, input logic x, input logic b, input logic [1:0] na,
      output int r);
      repeat (2) @(posedge clk);
      core <= c;
      ext <= x;
      w8 <= b;
      n_ack <= na;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      wt(0, 80, r);
   endtask : bus_cyc

   task automatic iack_cyc(input logic a);
      iack_lvl <= 3'h5;
      arb <= a;
      iack <= 1'b1;
      @(posedge clk);
      iack <= 1'b0;
      @(posedge clk);
   endtask : iack_cyc

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      #400000;
      n_fail++;
      finish_test();
   end

   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (5) @(posedge clk);
      rd_chk(spm_pkg::OFS_MCR, 16'h000c);
      rd_chk(spm_pkg::OFS_PCR, 16'h0040);
      rd_chk(spm_pkg::OFS_PTR, 16'h0100);
      rd_chk(spm_pkg::OFS_PERIODIC_CONTROL_REG, 16'h000f);
      for (int i = 0; i < 4; i++) begin
         wr_reg(spm_pkg::OFS_MCR, 16'(i) | 16'h0008);
         rd_chk(spm_pkg::OFS_MCR, 16'(i) | 16'h000c);
         chk(16'(show), 16'(i != 0));
         chk(16'(arben), 16'(i != 1));
      end
      sup <= 1'b0;
      wr_reg(spm_pkg::OFS_PERIODIC_CONTROL_REG, 16'h0123);
      rd_chk(spm_pkg::OFS_PERIODIC_CONTROL_REG, 16'h0000);
      sup <= 1'b1;
      rd_chk(spm_pkg::OFS_PERIODIC_CONTROL_REG, 16'h000f);
      wr_reg(spm_pkg::OFS_MCR, 16'h0000);
      sup <= 1'b0;
      wr_reg(spm_pkg::OFS_PERIODIC_CONTROL_REG, 16'h0042);
      rd_chk(spm_pkg::OFS_PERIODIC_CONTROL_REG, 16'h0042);
      sup <= 1'b1;
      $display("configuration tests done");
      wr_reg(spm_pkg::OFS_PCR, 16'h0003);
      bus_cyc(1'b1, 1'b0, 1'b0, 2'h0, n0);
      chk(16'(n0 >= 9 && n0 <= 11), 16'h0001);
      for (int b = 0; b < 3; b++) begin
         wr_reg(spm_pkg::OFS_PCR, 16'(b));
         bus_cyc(1'b1, 1'b0, 1'b0, 2'h0, n);
         chk(16'(n), 16'(n0 + (64 >> b) - 8));
      end
      wr_reg(spm_pkg::OFS_PCR, 16'h0003);
      bus_cyc(1'b1, 1'b0, 1'b0, 2'h1, n);
      chk(16'(n), 16'd80);
      // autovector alone must also end the cycle
      autovector_request <= 1'b1;
      bus_cyc(1'b1, 1'b0, 1'b0, 2'h0, n);
      chk(16'(n), 16'd80);
      autovector_request <= 1'b0;
      bus_cyc(1'b0, 1'b0, 1'b0, 2'h0, n);
      chk(16'(n), 16'd80);
      bus_cyc(1'b1, 1'b1, 1'b0, 2'h0, n);
      chk(16'(n), 16'd80);
      wr_reg(spm_pkg::OFS_PCR, 16'h0007);
      bus_cyc(1'b1, 1'b1, 1'b0, 2'h0, n);
      chk(16'(n), 16'(n0));
      bus_cyc(1'b1, 1'b0, 1'b1, 2'h1, n);
      chk(16'(n), 16'(n0));
      bus_cyc(1'b1, 1'b0, 1'b1, 2'h2, n);
      chk(16'(n), 16'd80);
      halt <= 1'b1;
      wt(1, 10, n);
      chk(16'(n), 16'd10);
      halt <= 1'b0;
      wr_reg(spm_pkg::OFS_PCR, 16'h000b);
      halt <= 1'b1;
      wt(1, 10, n);
      chk(16'(n < 4), 16'h0001);
      halt <= 1'b0;
      iack_cyc(1'b0);
      // the fault pulse stands only at the edge the task returns on
      chk(16'(fault), 16'h0001);
      iack_cyc(1'b1);
      wt(0, 5, n);
      chk(16'(n), 16'd5);
      $display("monitor tests done");
      wr_reg(spm_pkg::OFS_PCR, 16'h0080);
      wt(1, 3000, n);
      chk(16'(n >= 500 && n <= 520), 16'h0001);
      repeat (300) @(posedge clk);
      wr_reg(spm_pkg::OFS_SVC, 16'h0055);
      wr_reg(spm_pkg::OFS_PTR, 16'h0100);
      wr_reg(spm_pkg::OFS_SVC, 16'h00aa);
      wt(1, 3000, n);
      chk(16'(n >= 500 && n <= 520), 16'h0001);
      repeat (300) @(posedge clk);
      wr_reg(spm_pkg::OFS_SVC, 16'h0055);
      wr_reg(spm_pkg::OFS_SVC, 16'h0012);
      wr_reg(spm_pkg::OFS_SVC, 16'h00aa);
      wt(1, 3000, n);
      chk(16'(n < 300), 16'h0001);
      wr_reg(spm_pkg::OFS_PCR, 16'h0090);
      wt(1, 3000, n);
      chk(16'(n < 520), 16'h0001);
      wr_reg(spm_pkg::OFS_SVC, 16'h0055);
      wr_reg(spm_pkg::OFS_SVC, 16'h00aa);
      wt(1, 3000, n);
      chk(16'(n >= 2030 && n <= 2060), 16'h0001);
      wr_reg(spm_pkg::OFS_PCR, 16'h0003);
      $display("watchdog tests done");
      ext_lvl <= 3'h5;
      wr_reg(spm_pkg::OFS_PERIODIC_CONTROL_REG, 16'h0542);
      wr_reg(spm_pkg::OFS_PTR, 16'h0003);
      wt(2, 200, n);
      chk(16'(lvl), 16'h0005);
      chk(16'(from_pit), 16'h0001);
      mask <= 3'h5;
      repeat (2) @(posedge clk);
      chk(16'(from_pit), 16'h0000);
      mask <= 3'h0;
      iack_cyc(1'b1);
      chk(16'(vv), 16'h0001);
      chk(16'(vec), 16'h0042);
      repeat (3) @(posedge clk);
      wt(2, 200, n);
      chk(16'(n >= 48 && n <= 60), 16'h0001);
      iack_cyc(1'b1);
      wr_reg(spm_pkg::OFS_PTR, 16'h0006);
      wt(2, 200, n);
      chk(16'(n >= 42 && n <= 60), 16'h0001);
      iack_cyc(1'b1);
      repeat (3) @(posedge clk);
      wt(2, 200, n);
      chk(16'(n >= 105 && n <= 120), 16'h0001);
      wr_reg(spm_pkg::OFS_PTR, 16'h0000);
      iack_cyc(1'b1);
      wt(2, 300, n);
      chk(16'(n), 16'd300);
      wr_reg(spm_pkg::OFS_PERIODIC_CONTROL_REG, 16'h0042);
      wr_reg(spm_pkg::OFS_PTR, 16'h0003);
      wt(2, 300, n);
      chk(16'(n), 16'd300);
      $display("periodic timer tests done");
      finish_test();
   end
endmodule : spm_top_tb
